// ---- bench/uef_event_flags_assertions.sv ----
`timescale 1ns/100ps
module uef_event_flags_assertions (
  input wire        MCLK_IN,        // Clock
  input wire        SYS_RST_IN,     // Async reset
  input wire        BUS_SUSPEND_IN, // Suspend pulse
  input wire [3:0]  IN_EVENT_IN,    // IN events
  input wire        ARVALID,        // Read address valid
  input wire        ARREADY,        // Read address ready
  input wire [7:0]  ARADDR,         // Read address
  input wire        RVALID,         // Read data valid
  input wire [31:0] RDATA,          // Read data
  input wire        USB_IRQ_OUT,    // Interrupt
  input wire        SUSPEND_MD_OUT  // Suspend mode
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Read address accepted this cycle
  wire ar_take = ARVALID && ARREADY;
  read_answer_a: assert property (ar_take |=> RVALID)
    else $error("Read not answered next cycle");
  rvalid_cause_a: assert property ($rose(RVALID) |-> $past(ar_take))
    else $error("Read data without a request");
  in_layout_a: assert property (ar_take && ARADDR == 8'h08 |=>
    RDATA[31:4] == '0) else $error("IN flag upper bits set");
  out_layout_a: assert property (ar_take && ARADDR == 8'h10 |=>
    RDATA[31:4] == '0 && !RDATA[0]) else $error("OUT flag spare bits set");
  frame_high_a: assert property (ar_take && ARADDR == 8'h34 |=>
    RDATA[31:3] == '0) else $error("Frame high spare bits set");
  irq_follow_a: assert property (|IN_EVENT_IN |-> ##2 USB_IRQ_OUT)
    else $error("Interrupt missing after IN event");
  reset_quiet_a: assert property ($fell(SYS_RST_IN) |->
    !USB_IRQ_OUT && !SUSPEND_MD_OUT) else $error("Outputs set after reset");
  suspend_cause_a: assert property ($rose(SUSPEND_MD_OUT) |->
    $past(BUS_SUSPEND_IN) || $past(BUS_SUSPEND_IN, 2))
    else $error("Suspend mode without suspend signaling");
endmodule // uef_event_flags_assertions
bind uef_event_flags uef_event_flags_assertions chk_u (
  .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .ARADDR(ARADDR),
  .BUS_SUSPEND_IN(BUS_SUSPEND_IN), .IN_EVENT_IN(IN_EVENT_IN),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RDATA(RDATA),
  .USB_IRQ_OUT(USB_IRQ_OUT), .SUSPEND_MD_OUT(SUSPEND_MD_OUT));

// ---- bench/uef_host_model.sv ----
`timescale 1ns/100ps
module uef_host_model (
  input  wire        clk_in,     // Device clock
  output reg         sof_out,    // SOF token pulse
  output reg  [10:0] frame_out,  // Frame number, valid with token
  output reg  [2:0]  sig_out,    // Reset, resume, suspend pulses
  output reg  [3:0]  in_ev_out,  // IN endpoint completions
  output reg  [3:1]  out_ev_out  // OUT endpoint completions
);
  // Lines idle low, frame holds no meaning at start
  initial begin
    {sof_out, sig_out, in_ev_out, out_ev_out} = 11'h000;
    frame_out = 11'h7FF;
  end
  // One-cycle event pulse; frame flips after the token so a
  // design that samples it late reads a wrong number
  task send(input s, input [10:0] fr, input [2:0] sg, input [3:0] ie,
            input [3:1] oe);
    @(posedge clk_in);
    {sof_out, frame_out, sig_out} <= {s, fr, sg};
    {in_ev_out, out_ev_out} <= {ie, oe};
    @(posedge clk_in);
    {sof_out, sig_out, in_ev_out, out_ev_out} <= 11'h000;
    frame_out <= ~fr;
  endtask
endmodule // uef_host_model

// ---- bench/usb_event_flags_frame_number_tb_top.sv ----
`timescale 1ns/100ps
`include "uef_defines.vh"
module usb_event_flags_frame_number_tb_top;
  // Bench-driven inputs, idle at time zero
  logic        MCLK_IN = 1'b0, SYS_RST_IN = 1'b1;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic        ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000, rd_data;
  logic [3:0]  WSTRB = 4'h0;
  logic [1:0]  rd_resp;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, irq, susp, sof;
  wire [1:0]   BRESP, RRESP;
  wire [31:0]  RDATA;
  wire [10:0]  frame;
  wire [2:0]   sig;
  wire [3:0]   in_ev;
  wire [3:1]   out_ev;
  integer      num_errors = 0, comparisons = 0, i;
  logic [7:0]  regs [5] = '{8'h02, 8'h04, 8'h06, 8'h0C, 8'h0D};
  // Short frame timeout keeps the synthesized frame test brief
  uef_event_flags #(.SOF_TIMEOUT(50)) dut_u (
    .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .CLK_EN_IN(1'b1),
    .USB_RST_IN(1'b0), .SOF_TOKEN_IN(sof), .SOF_FRAME_IN(frame),
    .BUS_RESET_IN(sig[2]), .BUS_RESUME_IN(sig[1]),
    .BUS_SUSPEND_IN(sig[0]), .IN_EVENT_IN(in_ev), .OUT_EVENT_IN(out_ev),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .USB_IRQ_OUT(irq), .SUSPEND_MD_OUT(susp));
  uef_host_model host_u (.clk_in(MCLK_IN), .sof_out(sof), .frame_out(frame),
    .sig_out(sig), .in_ev_out(in_ev), .out_ev_out(out_ev));
  // 40 MHz clock
  initial forever #12.5 MCLK_IN = ~MCLK_IN;
  // Compare and count
  task check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Single read, address held until taken
  task rd(input [7:0] idx);
    @(posedge MCLK_IN);
    ARVALID <= 1'b1;
    ARADDR <= {idx[5:0], 2'b00};
    RREADY <= 1'b1;
    @(posedge MCLK_IN);
    while (ARREADY !== 1'b1) @(posedge MCLK_IN);
    ARVALID <= 1'b0;
    while (RVALID !== 1'b1) @(posedge MCLK_IN);
    rd_data = RDATA;
    rd_resp = RRESP;
    RREADY <= 1'b0;
  endtask
  // Single write, address and data released as each is taken
  task wr(input [7:0] idx, input [31:0] d);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge MCLK_IN);
    {AWVALID, WVALID, BREADY, WSTRB} <= 7'h7F;
    AWADDR <= {idx[5:0], 2'b00};
    WDATA <= d;
    while (a || w) begin
      @(posedge MCLK_IN);
      if (a && AWREADY === 1'b1) begin
        a = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    while (BVALID !== 1'b1) @(posedge MCLK_IN);
    BREADY <= 1'b0;
  endtask
  // Host event, interrupt level, then one register read
  task ev_read(input s, input [10:0] fr, input [2:0] sg, input [3:0] ie,
               input [3:1] oe, input [7:0] idx, input [7:0] exp, input q);
    host_u.send(s, fr, sg, ie, oe);
    repeat (3) @(posedge MCLK_IN);
    check("irq", irq, q);
    rd(idx);
    check($sformatf("reg %h", idx), rd_data, exp);
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (3000) @(posedge MCLK_IN);
    num_errors++;
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge MCLK_IN);
    SYS_RST_IN <= 1'b0;
    for (i = 0; i < 5; i++) begin
      rd(regs[i]);
      check("reset value", rd_data, '0);
    end
    wr(`UEF_IDX_IN_FLAGS, 32'h0000_00FF);
    rd(`UEF_IDX_IN_FLAGS);
    check("flags read-only", rd_data, '0);
    rd(8'h20);
    check("unmapped resp", rd_resp, 2'h2);
    $display("test reset_access done");
    ev_read(0, '0, '0, 4'hF, '0, `UEF_IDX_IN_FLAGS, 8'h0F, 1);
    rd(`UEF_IDX_IN_FLAGS);
    check("in cleared", rd_data, '0);
    check("irq cleared", irq, 1'b0);
    wr(`UEF_IDX_OUT_ENABLE, '0);
    ev_read(0, '0, '0, '0, 3'h7, `UEF_IDX_OUT_FLAGS, 8'h0E, 0);
    $display("test endpoint_flags done");
    ev_read(0, '0, 3'h4, '0, '0, `UEF_IDX_CM_FLAGS, 8'h04, 1);
    // Bus reset masks suspend again, so enable all common sources
    wr(`UEF_IDX_CM_ENABLE, 32'h0000_000F);
    ev_read(0, '0, 3'h1, '0, '0, `UEF_IDX_CM_FLAGS, 8'h00, 0);
    ev_read(0, '0, 3'h2, '0, '0, `UEF_IDX_CM_FLAGS, 8'h00, 0);
    wr(`UEF_IDX_CONTROL, 32'h0000_0001);
    ev_read(0, '0, 3'h1, '0, '0, `UEF_IDX_CM_FLAGS, 8'h01, 1);
    check("suspend mode", susp, 1'b1);
    ev_read(0, '0, 3'h2, '0, '0, `UEF_IDX_CM_FLAGS, 8'h02, 1);
    repeat (2) @(posedge MCLK_IN);
    check("suspend left", susp, 1'b0);
    $display("test bus_signaling done");
    ev_read(1, 11'h5A3, '0, '0, '0, `UEF_IDX_CM_FLAGS, 8'h08, 1);
    rd(`UEF_IDX_FRAME_LOW);
    check("frame low", rd_data, 8'hA3);
    rd(`UEF_IDX_FRAME_HIGH);
    check("frame high", rd_data, 8'h05);
    repeat (60) @(posedge MCLK_IN);
    rd(`UEF_IDX_CM_FLAGS);
    check("synth sof", rd_data, 8'h08);
    $display("test frame done");
    complete_run;
  end
endmodule // usb_event_flags_frame_number_tb_top

// ---- hdl/uef_defines.vh ----
`ifndef UEF_DEFINES_VH
`define UEF_DEFINES_VH
// Register indices (printed offsets), byte address is four times these
`define UEF_IDX_IN_FLAGS    8'h02
`define UEF_IDX_OUT_FLAGS   8'h04
`define UEF_IDX_CM_FLAGS    8'h06
`define UEF_IDX_IN_ENABLE   8'h07
`define UEF_IDX_OUT_ENABLE  8'h09
`define UEF_IDX_CM_ENABLE   8'h0B
`define UEF_IDX_FRAME_LOW   8'h0C
`define UEF_IDX_FRAME_HIGH  8'h0D
`define UEF_IDX_CONTROL     8'h10
`define UEF_IDX_STATUS      8'h11
// Enable reset values
`define UEF_RST_IN_ENABLE   4'hF
`define UEF_RST_OUT_ENABLE  4'hE
`define UEF_RST_CM_ENABLE   4'h6
// Common flag bit positions
`define UEF_BIT_SOF         3
`define UEF_BIT_RESET       2
`define UEF_BIT_RESUME      1
`define UEF_BIT_SUSPEND     0
// Control register bit positions
`define UEF_BIT_SUSP_EN     0
// Frame period 1 ms plus slack, in ns, and in cycles at 25 ns
`define UEF_FRAME_NS        1000000
`define UEF_CLK_NS          25
`define UEF_SOF_SLACK_NS    2000
`endif

// ---- hdl/uef_event_flags.v ----
`timescale 1ns/100ps
`include "uef_defines.vh"
// Overview of the block
// Bus-side event pulses arrive already decoded and one cycle long.
// Each pulse lands in a sticky flag (resume only while suspended, suspend only when enabled); a read of the word clears it.
// The request line is the OR of enabled flags, taken from a flop.
// The frame number is held as one eleven-bit word so that both
// halves always belong to the same frame.
// A frame watchdog stands in for a token that never arrived.
// Limitation: the watchdog only runs after a first real token,
// since before that there is no frame time to predict.
// Register words are one byte wide, placed in bits 7:0 of a word.
module uef_event_flags #(
  parameter SOF_TIMEOUT = (`UEF_FRAME_NS + `UEF_SOF_SLACK_NS) / `UEF_CLK_NS
) (
  input  wire        MCLK_IN,        // System clock, 40 MHz
  input  wire        SYS_RST_IN,     // Async reset, active high
  input  wire        CLK_EN_IN,      // Freezes all state when low
  input  wire        USB_RST_IN,     // USB-side reset pulse
  input  wire        SOF_TOKEN_IN,   // Valid SOF token pulse
  input  wire [10:0] SOF_FRAME_IN,   // Frame number with SOF token
  input  wire        BUS_RESET_IN,   // Reset signaling detected pulse
  input  wire        BUS_RESUME_IN,  // Resume signaling detected pulse
  input  wire        BUS_SUSPEND_IN, // Suspend signaling detected pulse
  input  wire [3:0]  IN_EVENT_IN,    // IN endpoint event pulses
  input  wire [3:1]  OUT_EVENT_IN,   // OUT endpoint event pulses
  input  wire        AWVALID,        // Write address valid
  output reg         AWREADY,        // Write address ready
  input  wire [7:0]  AWADDR,         // Write byte address
  input  wire        WVALID,         // Write data valid
  output reg         WREADY,         // Write data ready
  input  wire [31:0] WDATA,          // Write data
  input  wire [3:0]  WSTRB,          // Write byte strobes
  output reg         BVALID,         // Write response valid
  input  wire        BREADY,         // Write response ready
  output reg  [1:0]  BRESP,          // Write response code
  input  wire        ARVALID,        // Read address valid
  output reg         ARREADY,        // Read address ready
  input  wire [7:0]  ARADDR,         // Read byte address
  output reg         RVALID,         // Read data valid
  input  wire        RREADY,         // Read data ready
  output reg  [31:0] RDATA,          // Read data
  output reg  [1:0]  RRESP,          // Read response code
  output reg         USB_IRQ_OUT,    // Combined interrupt, level
  output reg         SUSPEND_MD_OUT  // Suspend mode status
);
  reg  [3:0]  in_flags_ff;           // IN endpoint flags
  reg  [3:1]  out_flags_ff;          // OUT endpoint flags
  reg  [3:0]  cm_flags_ff;           // Common bus event flags
  reg  [3:0]  in_en_ff;              // IN enables
  reg  [3:1]  out_en_ff;             // OUT enables
  reg  [3:0]  cm_en_ff;              // Common enables
  reg         susp_en_ff;            // Suspend detect enable
  reg         susp_md_ff;            // Suspend mode status
  reg         resume_seen_ff;        // Resume detected since suspend
  reg  [10:0] frame_ff;              // Last frame number
  reg  [31:0] sof_cnt_ff;            // Time since last SOF
  reg         sof_armed_ff;          // A first SOF has been seen
  reg         aw_held_ff;            // Write address captured
  reg         w_held_ff;             // Write data captured
  reg  [7:0]  aw_addr_ff;            // Captured write address
  reg  [31:0] w_data_ff;             // Captured write data
  reg         w_lane0_ff;            // Low byte strobe captured
  reg  [7:0]  rd_data;               // Read mux result
  reg         rd_ok;                 // Read address mapped
  wire        aw_take;               // Address handshake
  wire        w_take;                // Data handshake
  wire        ar_take;               // Read address handshake
  wire        wr_go;                 // Write commits this cycle
  wire [5:0]  rd_idx;                // Read word index
  wire [5:0]  wr_idx;                // Write word index
  wire        rd_in;                 // Read of IN flags
  wire        rd_out;                // Read of OUT flags
  wire        rd_cm;                 // Read of common flags
  wire        sof_fake;              // Synthesized SOF
  wire        sof_evt;               // Real or synthesized SOF
  wire [3:0]  cm_set;                // Common flag set terms
  wire        irq_nxt;               // Next interrupt level

  // Handshake decode
  // A channel moves one item when valid and ready meet at an edge.
  // Address and data may come in either order; the write commits
  // only once both are held and no response is still pending.
  // Word index drops the two byte-select bits of the address.
  // Trade-off: ready stays low after each transfer until its response is taken,
  // which costs throughput but keeps a single transfer in flight
  // and makes the read-clear side effect happen exactly once.
  assign aw_take = AWVALID & AWREADY;
  assign w_take  = WVALID & WREADY;
  assign ar_take = ARVALID & ARREADY;
  assign wr_go   = aw_held_ff & w_held_ff & ~BVALID;
  assign rd_idx  = ARADDR[7:2];
  assign wr_idx  = aw_addr_ff[7:2];
  // Read-clear side effects fire on the accepted read address
  assign rd_in   = ar_take & (rd_idx == `UEF_IDX_IN_FLAGS);
  assign rd_out  = ar_take & (rd_idx == `UEF_IDX_OUT_FLAGS);
  assign rd_cm   = ar_take & (rd_idx == `UEF_IDX_CM_FLAGS);

  // Frame timer expiry stands in for a lost or corrupted SOF
  assign sof_fake = sof_armed_ff & (sof_cnt_ff >= SOF_TIMEOUT);
  assign sof_evt  = SOF_TOKEN_IN | sof_fake;

  // Common event sources with their qualifiers
  assign cm_set[`UEF_BIT_SOF]     = sof_evt;
  assign cm_set[`UEF_BIT_RESET]   = BUS_RESET_IN;
  assign cm_set[`UEF_BIT_RESUME]  = BUS_RESUME_IN & susp_md_ff;
  assign cm_set[`UEF_BIT_SUSPEND] = BUS_SUSPEND_IN & susp_en_ff;

  // Only enabled flags reach the request line
  assign irq_nxt = |(in_flags_ff & in_en_ff) |
                   |(out_flags_ff & out_en_ff) |
                   |(cm_flags_ff & cm_en_ff);

  // Read mux, reserved bits zero
  // Decoded from the live read address, so the value captured at
  // the accepting edge is the one before any clear takes effect.
  // Unused bit positions are tied low here rather than stored,
  // so no reserved bit can ever read back as one.
  // Unmapped words give zero data and a slave error response.
  always @* begin
    rd_ok   = 1'b1;
    rd_data = 8'h00;
    if (rd_idx == `UEF_IDX_IN_FLAGS) begin
      rd_data = {4'h0, in_flags_ff};
    end else if (rd_idx == `UEF_IDX_OUT_FLAGS) begin
      rd_data = {4'h0, out_flags_ff, 1'b0};
    end else if (rd_idx == `UEF_IDX_CM_FLAGS) begin
      rd_data = {4'h0, cm_flags_ff};
    end else if (rd_idx == `UEF_IDX_IN_ENABLE) begin
      rd_data = {4'h0, in_en_ff};
    end else if (rd_idx == `UEF_IDX_OUT_ENABLE) begin
      rd_data = {4'h0, out_en_ff, 1'b0};
    end else if (rd_idx == `UEF_IDX_CM_ENABLE) begin
      rd_data = {4'h0, cm_en_ff};
    end else if (rd_idx == `UEF_IDX_FRAME_LOW) begin
      rd_data = frame_ff[7:0];
    end else if (rd_idx == `UEF_IDX_FRAME_HIGH) begin
      rd_data = {5'h00, frame_ff[10:8]};
    end else if (rd_idx == `UEF_IDX_CONTROL) begin
      rd_data = {7'h00, susp_en_ff};
    end else if (rd_idx == `UEF_IDX_STATUS) begin
      rd_data = {6'h00, resume_seen_ff, susp_md_ff};
    end else begin
      rd_ok   = 1'b0;                                   // Unmapped
    end
  end

  // Bus slave handshakes; one read, one write at a time
  // Read data is registered on the same edge that takes the address.
  // Valid then stands until the master shows ready at an edge.
  // The write response follows once both halves are held.
  // Only the low byte lane carries register data; other lanes
  // are accepted and ignored.
  // Hazard: a new read is not taken while read data still stands,
  // otherwise a second clear could hit flags nobody has seen.
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      AWREADY    <= 1'b0;
      WREADY     <= 1'b0;
      BVALID     <= 1'b0;
      BRESP      <= 2'b00;
      ARREADY    <= 1'b0;
      RVALID     <= 1'b0;
      RDATA      <= 32'h0000_0000;
      RRESP      <= 2'b00;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_lane0_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      // Each ready is offered only while its own channel holds nothing
      AWREADY <= ~aw_held_ff & ~aw_take & ~BVALID;
      WREADY  <= ~w_held_ff & ~w_take & ~BVALID;
      ARREADY <= ~RVALID & ~ar_take;
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= AWADDR;
      end
      if (w_take) begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= WDATA;
        w_lane0_ff <= WSTRB[0];
      end
      if (wr_go) begin
        BVALID     <= 1'b1;
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        // Writes to flag and frame words are ignored, answered OKAY
        BRESP <= (wr_idx <= `UEF_IDX_STATUS) ? 2'b00 : 2'b10;
      end else if (BVALID & BREADY) begin
        BVALID <= 1'b0;
      end
      if (ar_take) begin
        RVALID <= 1'b1;
        RDATA  <= {24'h00_0000, rd_data};
        RRESP  <= rd_ok ? 2'b00 : 2'b10;
      end else if (RVALID & RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // Writable enables and control; flags and frame are read-only
  // A bus reset turns on every source except suspend, so that the
  // software sees reset and frame events before it has set up.
  // Suspend stays masked because it would fire while the host is
  // still bringing the bus up.
  // Writes need the low byte strobe; a write without it is a
  // no-op that is still answered.
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      in_en_ff   <= `UEF_RST_IN_ENABLE;
      out_en_ff  <= 3'h7;
      cm_en_ff   <= `UEF_RST_CM_ENABLE;
      susp_en_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (USB_RST_IN | BUS_RESET_IN) begin
        // Bus reset enables all but suspend
        in_en_ff <= 4'hF;
        out_en_ff <= 3'h7;
        cm_en_ff <= `UEF_RST_CM_ENABLE | 4'h8;
      end else if (wr_go & w_lane0_ff) begin
        if (wr_idx == `UEF_IDX_IN_ENABLE) begin
          in_en_ff <= w_data_ff[3:0];
        end else if (wr_idx == `UEF_IDX_OUT_ENABLE) begin
          out_en_ff <= w_data_ff[3:1];
        end else if (wr_idx == `UEF_IDX_CM_ENABLE) begin
          cm_en_ff <= w_data_ff[3:0];
        end else if (wr_idx == `UEF_IDX_CONTROL) begin
          susp_en_ff <= w_data_ff[`UEF_BIT_SUSP_EN];
        end
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  // Why: an event landing in the same cycle as the clearing read
  // was not part of the data returned, so dropping it would lose
  // it for good; keeping it just means one more interrupt.
  // Flags clear on the accepting edge of the read address.
  // A USB-side reset pulse empties every flag at once.
  // Software writes never reach these flops.
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      in_flags_ff  <= 4'h0;
      out_flags_ff <= 3'h0;
      cm_flags_ff  <= 4'h0;
    end else if (CLK_EN_IN) begin
      if (USB_RST_IN) begin
        in_flags_ff  <= 4'h0;
        out_flags_ff <= 3'h0;
        cm_flags_ff  <= 4'h0;
      end else begin
        in_flags_ff  <= (rd_in ? 4'h0 : in_flags_ff) | IN_EVENT_IN;
        out_flags_ff <= (rd_out ? 3'h0 : out_flags_ff) | OUT_EVENT_IN;
        cm_flags_ff  <= (rd_cm ? 4'h0 : cm_flags_ff) | cm_set;
      end
    end
  end

  // Suspend mode tracking; cleared by reset or a resume read
  // Entry needs suspend detection enabled in the control word.
  // A resume while suspended is remembered until the common flag
  // word is read; that read then takes the device out of suspend.
  // Reset signaling on the bus always ends suspend at once.
  // Priority: reset, then the clearing read, then new events.
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      susp_md_ff     <= 1'b0;
      resume_seen_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (USB_RST_IN | BUS_RESET_IN) begin
        susp_md_ff     <= 1'b0;
        resume_seen_ff <= 1'b0;
      end else if (rd_cm & resume_seen_ff) begin
        susp_md_ff     <= 1'b0;
        resume_seen_ff <= 1'b0;
      end else if (BUS_RESUME_IN & susp_md_ff) begin
        resume_seen_ff <= 1'b1;
      end else if (BUS_SUSPEND_IN & susp_en_ff) begin
        susp_md_ff <= 1'b1;
      end
    end
  end

  // Frame capture and SOF watchdog; watchdog silent while suspended
  // All eleven bits load together from the token's frame field.
  // The counter restarts on every real or synthesized frame.
  // Limitation: a synthesized frame keeps the old frame number,
  // since no number was received for it.
  // While suspended the host sends no frames, so the watchdog is
  // disarmed to avoid a stream of false frame events.
  // The counter is wide on purpose so long timeouts fit.
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      frame_ff     <= 11'h000;
      sof_cnt_ff   <= 32'h0000_0000;
      sof_armed_ff <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (USB_RST_IN | BUS_RESET_IN) begin
        frame_ff     <= 11'h000;
        sof_cnt_ff   <= 32'h0000_0000;
        sof_armed_ff <= 1'b0;
      end else if (SOF_TOKEN_IN) begin
        frame_ff     <= SOF_FRAME_IN;
        sof_cnt_ff   <= 32'h0000_0001;
        sof_armed_ff <= 1'b1;
      end else if (susp_md_ff) begin
        sof_armed_ff <= 1'b0;                           // No frames
      end else if (sof_fake) begin
        sof_cnt_ff <= 32'h0000_0001;
      end else if (sof_armed_ff) begin
        sof_cnt_ff <= sof_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Registered outputs
  // Both pins come straight from flops so they never glitch
  // while the flag logic settles; the cost is one cycle of delay
  // between a flag setting and the request line rising.
  // Suspend status follows the internal state one cycle late.
  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      USB_IRQ_OUT    <= 1'b0;
      SUSPEND_MD_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      USB_IRQ_OUT    <= irq_nxt;
      SUSPEND_MD_OUT <= susp_md_ff;
    end
  end
endmodule // uef_event_flags
